// *** rtl/t2cr_map.svh ***
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef T2CR_MAP_SVH
`define T2CR_MAP_SVH
`define T2CR_OFF_CONTROL   4'h0
`define T2CR_OFF_MODE      4'h4
`define T2CR_OFF_COUNT     4'h8
`define T2CR_OFF_HOLD      4'hc
`define T2CR_BIT_OVF       7
`define T2CR_BIT_EXT       6
`define T2CR_BIT_EXTEN     3
`define T2CR_BIT_RUN       2
`define T2CR_BIT_CSRC      1
`define T2CR_BIT_CPRL      0
`define T2CR_BIT_DOWN_COUNT_ENABLE      0
`define T2CR_CNT_MAX       16'hffff
`define T2CR_CNT_RST       16'h0000
`define T2CR_HOLD_RST      16'h0000
`define T2CR_OSC_PER_TICK  4'hc
`define T2CR_RESP_OKAY     2'h0
`define T2CR_RESP_SLVERR   2'h2
`endif

// *** rtl/t2cr_pkg.sv ***
// Types of the capture and auto-reload timer
package t2cr_pkg;
  typedef struct packed {
    logic [3:0]  presc;
    logic        tick;
    logic        evt_smp;
    logic        trg_smp;
    logic [15:0] cnt;
    logic [15:0] hold;
    logic        ovf;
    logic        ext;
    logic        ext_en;
    logic        run;
    logic        csrc;
    logic        cprl;
    logic        down_count_enable;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } t2cr_state_t;
endpackage : t2cr_pkg

// *** rtl/t2cr_top.sv ***
// Sixteen-bit capture and auto-reload timer with an AXI4-Lite register slave
`timescale 1ns/10ps
`include "t2cr_map.svh"

// Notes on behaviour
// - Sixteen-bit counter works as timer or event counter per count source select.
// - Capture and auto-reload modes live here; baud-rate mode is out of scope.
// - Capture mode without trigger enable sets overflow flag on each overflow.
// - Capture with trigger enable copies count into hold on trigger falling edge.
// - Capturing trigger edge sets external flag; both flags share the interrupt, ext flag only while down count enable is zero.
// - Capture mode never reloads and counting continues through captures.
// - Down count enable selects up/down auto-reload, trigger pin picks direction; reset clears it.
// - Up-only auto-reload counts to ffff, sets overflow flag, reloads from hold.
// - Up-only with trigger enable also reloads on trigger falling edge, sets ext flag.
// - Up-only auto-reload requests interrupt while either flag is one.
// - Down count enabled, trigger high: count up, overflow sets flag and reloads.
// - Down count enabled, trigger low: count down, underflow at hold loads ffff.
// - Down count enabled: ext flag toggles on wrap, requests no interrupt.
// - Overflow flag is set only by hardware and cleared only by software.
// - Source select 0 counts oscillator/12 ticks, 1 counts event pin falls.
module t2cr_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ext_event_pin_i,
  input  wire logic        ext_trigger_pin_i,
  output logic             timer_irq_o,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [31:0] s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o
);
  import t2cr_pkg::*;

  t2cr_state_t s;
  t2cr_state_t next_s;

  logic        evt_fall;
  logic        trg_fall;
  logic        step;
  logic        at_max;
  logic        do_wr;
  logic [7:0]  ctl_rd;
  logic [15:0] wr16;
  logic [3:0]  araddr;
  logic        mode_cap;
  logic        mode_up;
  logic        trg_hit;
  logic        wrap_up;
  logic        wrap_down;
  logic [31:0] rd_word;

  //****************************************************************
  // Timer core
  //****************************************************************

  // Edges seen between two successive tick samples
  assign evt_fall = s.tick & s.evt_smp & ~ext_event_pin_i;
  assign trg_fall = s.tick & s.trg_smp & ~ext_trigger_pin_i;
  // Pick tick or event edge, gated by run
  assign step     = s.run & (s.csrc ? evt_fall : s.tick);
  assign at_max   = (s.cnt == `T2CR_CNT_MAX);
  assign do_wr    = s.aw_got & s.w_got & ~s.bvalid;
  assign araddr   = s_axi_araddr_i[3:0];

  //****************************************************************
  // Mode and event decode
  //****************************************************************

  // Capture when select is one, else up-only or up/down auto-reload
  assign mode_cap  = s.cprl;
  assign mode_up   = ~s.cprl & ~s.down_count_enable;
  // Trigger edge that may capture or reload
  assign trg_hit   = trg_fall & s.ext_en;
  // Wrap points of the up/down counter, direction from the live pin
  assign wrap_up   = ext_trigger_pin_i & at_max;
  assign wrap_down = ~ext_trigger_pin_i & (s.cnt == s.hold);

  // Control register image
  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[`T2CR_BIT_OVF]   = s.ovf;
    ctl_rd[`T2CR_BIT_EXT]   = s.ext;
    ctl_rd[`T2CR_BIT_EXTEN] = s.ext_en;
    ctl_rd[`T2CR_BIT_RUN]   = s.run;
    ctl_rd[`T2CR_BIT_CSRC]  = s.csrc;
    ctl_rd[`T2CR_BIT_CPRL]  = s.cprl;
  end

  // Byte-lane merge for the sixteen-bit registers
  always_comb begin
    wr16 = (s.awaddr == `T2CR_OFF_HOLD) ? s.hold : s.cnt;
    if (s.wstrb[0]) begin
      wr16[7:0] = s.wdata[7:0];
    end
    if (s.wstrb[1]) begin
      wr16[15:8] = s.wdata[15:8];
    end
  end

  //****************************************************************
  // Register read mux
  //****************************************************************

  // Read word select from address bits 3:2; higher addresses alias the four registers
  always_comb begin
    unique case ({araddr[3:2], 2'b00})
      `T2CR_OFF_CONTROL: rd_word = {24'h000000, ctl_rd};
      `T2CR_OFF_MODE:    rd_word = {31'h00000000, s.down_count_enable};
      `T2CR_OFF_COUNT:   rd_word = {16'h0000, s.cnt};
      `T2CR_OFF_HOLD:    rd_word = {16'h0000, s.hold};
      default:           rd_word = 32'h00000000;
    endcase
  end

  // Next-state logic
  always_comb begin
    next_s = s;

    // Machine-cycle tick, one every twelve oscillator clocks
    if (s.presc == `T2CR_OSC_PER_TICK - 4'h1) begin
      next_s.presc = 4'h0;
      next_s.tick  = 1'b1;
    end else begin
      next_s.presc = s.presc + 4'h1;
      next_s.tick  = 1'b0;
    end
    if (s.tick) begin
      next_s.evt_smp = ext_event_pin_i;
      next_s.trg_smp = ext_trigger_pin_i;
    end

    //**************************************************************
    // Software writes, applied first so hardware events win
    //**************************************************************
    if (do_wr) begin
      unique case (s.awaddr)
        `T2CR_OFF_CONTROL: begin
          if (s.wstrb[0]) begin
            // Software may clear the overflow flag but never set it
            if (!s.wdata[`T2CR_BIT_OVF]) begin
              next_s.ovf = 1'b0;
            end
            next_s.ext    = s.wdata[`T2CR_BIT_EXT];
            next_s.ext_en = s.wdata[`T2CR_BIT_EXTEN];
            next_s.run    = s.wdata[`T2CR_BIT_RUN];
            next_s.csrc   = s.wdata[`T2CR_BIT_CSRC];
            next_s.cprl   = s.wdata[`T2CR_BIT_CPRL];
          end
        end
        `T2CR_OFF_MODE: begin
          if (s.wstrb[0]) begin
            next_s.down_count_enable = s.wdata[`T2CR_BIT_DOWN_COUNT_ENABLE];
          end
        end
        `T2CR_OFF_COUNT: next_s.cnt  = wr16;
        `T2CR_OFF_HOLD:  next_s.hold = wr16;
        default: ;
      endcase
    end

    //**************************************************************
    // Counting, capture and reload
    //**************************************************************
    if (mode_cap) begin
      // Capture mode: free running, never reloaded
      if (step) begin
        next_s.cnt = s.cnt + 16'h0001;
        if (at_max) begin
          next_s.ovf = 1'b1;
        end
      end
      if (trg_hit) begin
        next_s.hold = s.cnt;
        next_s.ext  = 1'b1;
      end
    end else if (mode_up) begin
      // Up-only auto-reload
      if (step) begin
        if (at_max) begin
          next_s.cnt = s.hold;
          next_s.ovf = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
      if (trg_hit) begin
        next_s.cnt = s.hold;
        next_s.ext = 1'b1;
      end
    end else if (step) begin
      // Up/down auto-reload, direction from trigger pin
      if (ext_trigger_pin_i) begin
        if (wrap_up) begin
          next_s.cnt = s.hold;
          next_s.ovf = 1'b1;
          next_s.ext = ~s.ext;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end else begin
        if (wrap_down) begin
          next_s.cnt = `T2CR_CNT_MAX;
          next_s.ovf = 1'b1;
          next_s.ext = ~s.ext;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
    end

    // Shared request; ext flag silent in up/down mode
    next_s.irq = next_s.ovf | (next_s.ext & ~next_s.down_count_enable);

    //**************************************************************
    // AXI4-Lite write channel
    //**************************************************************
    if (s_axi_awvalid_i && s.awready) begin
      next_s.awaddr  = {s_axi_awaddr_i[3:2], 2'b00};
      next_s.aw_got  = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid_i && s.wready) begin
      next_s.wdata  = s_axi_wdata_i;
      next_s.wstrb  = s_axi_wstrb_i;
      next_s.w_got  = 1'b1;
      next_s.wready = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `T2CR_RESP_OKAY;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    //**************************************************************
    // AXI4-Lite read channel
    //**************************************************************
    if (s_axi_arvalid_i && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = `T2CR_RESP_OKAY;
      next_s.rdata   = rd_word;
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.cnt     <= `T2CR_CNT_RST;
      s.hold    <= `T2CR_HOLD_RST;
      s.evt_smp <= 1'b1;  // Idle-high pins give no false edge
      s.trg_smp <= 1'b1;
      s.down_count_enable    <= 1'b0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  //****************************************************************
  // Outputs, all straight from flops
  //****************************************************************
  assign timer_irq_o     = s.irq;
  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o  = s.wready;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;

endmodule : t2cr_top

// *** sim/t2cr_monitor.sv ***
// Checker of the timer's bus handshakes and interrupt line
`timescale 1ns/10ps
module t2cr_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        timer_irq_o,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_BRESP_OKAY:
    assert property (s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0) else $error("bad bresp");
  AST_RRESP_OKAY:
    assert property (s_axi_rvalid_o |-> s_axi_rresp_o == 2'h0) else $error("bad rresp");
  AST_B_HOLD:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  AST_R_HOLD:
    assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  AST_R_ANSWER:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered");
  AST_B_ANSWER:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_awready_o && !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("late bvalid");
  AST_B_DONE:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o
      && s_axi_wready_o) else $error("write not closed");
  AST_IRQ_STICKY:
    assert property ($fell(timer_irq_o) |-> $rose(s_axi_bvalid_o))
    else $error("irq fell without write");
endmodule : t2cr_monitor

bind t2cr_top t2cr_monitor i_t2cr_monitor (.clk_i, .rst_i, .timer_irq_o, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .s_axi_rresp_o);

// *** sim/t2cr_pin_model.sv ***
// Outside world driving the timer's event and trigger pins
`timescale 1ns/10ps
module t2cr_pin_model (
  input  wire logic clk_i,
  input  wire logic trg_fall_i,
  input  wire logic evt_fall_i,
  input  wire logic trg_high_i,
  output logic      ext_event_pin_o,
  output logic      ext_trigger_pin_o
);
  logic [5:0] trg_cnt = 6'h00;
  logic [5:0] evt_cnt = 6'h00;
  // Levels held two ticks so a tick sample never misses them
  always @(posedge clk_i) begin
    if (trg_fall_i)
      trg_cnt <= 6'h18;
    else if (trg_cnt != 6'h00)
      trg_cnt <= trg_cnt - 6'h01;
    if (evt_fall_i)
      evt_cnt <= 6'h30;
    else if (evt_cnt != 6'h00)
      evt_cnt <= evt_cnt - 6'h01;
  end
  // Trigger low during a pulse, else the direction level
  assign ext_trigger_pin_o = trg_high_i && (trg_cnt == 6'h00);
  assign ext_event_pin_o   = !(evt_cnt > 6'h18);
endmodule : t2cr_pin_model

// *** sim/t2cr_tb_top.sv ***
// Self-checking bench of the capture and auto-reload timer
`timescale 1ns/10ps
module t2cr_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic        tf = 1'b0, ef = 1'b0, th = 1'b1;
  logic [3:0]  ws = 4'hf;
  logic        awr, wrd, bv, arr, rv, irq, evp, trp;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat, d, h;
  logic [1:0]  bres, rres;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  // ****
  // Clock, hang guard, design and pins
  // ****
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
  end
  t2cr_top i_t2cr_top (.clk_i(clk_i), .rst_i(rst_i), .ext_event_pin_i(evp),
    .ext_trigger_pin_i(trp), .timer_irq_o(irq), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(bres),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rres));
  t2cr_pin_model i_t2cr_pin_model (.clk_i(clk_i), .trg_fall_i(tf), .evt_fall_i(ef),
    .trg_high_i(th), .ext_event_pin_o(evp), .ext_trigger_pin_o(trp));
  // ****
  // Bus, pin and compare tasks
  // ****
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic pa, pw, pb;
    @(posedge clk_i);
    {pa, pw, pb} = 3'b111;
    awa <= a;
    wd <= v;
    {awv, wv, bry} <= 3'b111;
    while (pa || pw || pb) begin
      @(posedge clk_i);
      if (pa && awr) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wrd) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
      if (bv) begin
        pb = 1'b0;
        bry <= 1'b0;
      end
    end
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    logic p;
    @(posedge clk_i);
    p = 1'b1;
    ara <= a;
    {arv, rry} <= 2'b11;
    while (p) begin
      @(posedge clk_i);
      if (arr)
        arv <= 1'b0;
      if (rv) begin
        p = 1'b0;
        q = rdat;
        rry <= 1'b0;
      end
    end
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(n, e, q);
  endtask : rc
  task automatic tk(input int n);
    repeat (n * 12) @(posedge clk_i);
  endtask : tk
  task automatic fall(input logic trg);
    @(posedge clk_i);
    if (trg)
      tf <= 1'b1;
    else
      ef <= 1'b1;
    @(posedge clk_i);
    {tf, ef} <= 2'b00;
    repeat (48) @(posedge clk_i);
  endtask : fall
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("ctrl", 0, 0);
    rc("mode", 4, 0);
    rc("count", 8, 0);
    rc("hold", 12, 0);
    wr(0, 32'h80);
    rc("sw_no_set", 0, 0);
    ws <= 4'h2;
    wr(12, 32'hab77);
    ws <= 4'hf;
    rc("hold_lane", 12, 32'hab00);
    $display("reset test done");
    wr(12, 32'h1234);
    wr(8, 32'hfffe);
    wr(0, 32'h04);
    tk(3);
    rc("ovf", 0, 32'h84);
    rd(8, d);
    chk("reload", 1, d >= 32'h1234 && d < 32'h1238);
    chk("irq", 1, irq);
    wr(0, 0);
    chk("irq_clr", 0, irq);
    rd(8, d);
    tk(2);
    rc("stopped", 8, d);
    $display("reload test done");
    wr(8, 32'h0100);
    wr(0, 32'h0d);
    fall(1'b1);
    rd(12, h);
    chk("capture", 1, h >= 32'h100 && h < 32'h106);
    rd(8, d);
    chk("keeps_on", 1, d > h);
    rc("ext", 0, 32'h4d);
    chk("irq_ext", 1, irq);
    wr(0, 0);
    wr(8, 32'hfffe);
    wr(0, 32'h05);
    fall(1'b1);
    rc("cap_ovf", 0, 32'h85);
    rc("no_cap", 12, h);
    rd(8, d);
    chk("no_reload", 1, d < 32'h10);
    $display("capture test done");
    wr(0, 0);
    wr(8, 0);
    wr(0, 32'h06);
    repeat (3) fall(1'b0);
    rc("events", 8, 3);
    wr(0, 0);
    wr(12, 32'h0500);
    wr(8, 0);
    wr(0, 32'h0c);
    fall(1'b1);
    rd(8, d);
    chk("trg_reload", 1, d >= 32'h500 && d < 32'h508);
    rc("trg_ext", 0, 32'h4c);
    chk("irq_up", 1, irq);
    $display("event test done");
    wr(0, 0);
    wr(4, 1);
    th <= 1'b0;
    wr(12, 32'h10);
    wr(8, 32'h12);
    wr(0, 32'h04);
    tk(4);
    rc("under", 0, 32'hc4);
    rd(8, d);
    chk("to_ffff", 1, d >= 32'hfff0);
    wr(0, 32'h44);
    chk("ext_quiet", 0, irq);
    th <= 1'b1;
    tk(6);
    rc("up_wrap", 0, 32'h84);
    rd(8, d);
    chk("up_hold", 1, d >= 32'h10 && d < 32'h18);
    $display("down test done");
    rst_i <= 1'b1;
    repeat (24) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("rst_irq", 0, irq);
    rc("rst_ctrl", 0, 0);
    rc("rst_mode", 4, 0);
    rc("rst_count", 8, 0);
    $display("reset again test done");
    test_done();
  end
endmodule : t2cr_tb_top
